// *** hdl/tag_cmd_pkg.sv ***
/*
  Shared constants and carrier types for the tag command interpreter
  (counter read, password verify, signature read).
  Assumes a framing layer that delivers checked request bytes and appends CRC to replies.
*/
package tag_cmd_pkg;

  localparam logic [7:0] OP_COUNTER_READ    = 8'h39;
  localparam logic [7:0] OP_PASSWORD_VERIFY = 8'h1B;
  localparam logic [7:0] OP_SIGNATURE_READ  = 8'h3C;
  localparam logic [7:0] COUNTER_ARG        = 8'h02;
  localparam logic [7:0] SIGNATURE_ARG      = 8'h00;

  localparam logic [2:0] SHORT_REQ_LEN = 3'h2;
  localparam logic [2:0] PWD_REQ_LEN   = 3'h5;
  localparam int         RX_DEPTH      = 6;

  localparam logic [5:0] COUNTER_LAST_IDX = 6'h02;
  localparam logic [5:0] ACK_LAST_IDX     = 6'h01;
  localparam logic [5:0] SIG_LAST_IDX     = 6'h1F;

  localparam logic [3:0] NAK_CODE     = 4'h0;
  localparam logic [2:0] NO_LIMIT     = 3'h0;
  localparam logic       AUTH_RESET   = 1'b0;
  localparam logic [7:0] ZERO_BYTE    = 8'h00;

  localparam logic [1:0] KIND_COUNTER = 2'h0;
  localparam logic [1:0] KIND_ACK     = 2'h1;
  localparam logic [1:0] KIND_SIG     = 2'h2;

  // Content is arbitrary; production parts carry their own programmed value
  localparam logic [255:0] SIGNATURE_CONTENT =
    256'h5A3C_96E1_0F2D_4B78_C3A5_1E69_D287_F04B_6C1A_E359_27B8_4DF0_91C6_3A7E_05D2_B84F;

  typedef struct packed {
    logic       valid;
    logic       last;
    logic [7:0] data;
  } byte_beat_t;

  typedef struct packed {
    logic       counter_read_protect_flag;
    logic [7:0] first_protected_page;
    logic       protection_scope_bit;
    logic [2:0] failed_attempt_limit;
    logic [7:0] password_page;
    logic [7:0] password_ack_page;
  } tag_cfg_t;

  typedef struct packed {
    logic       valid;
    logic       is_write;
    logic [7:0] page;
  } page_req_t;

  typedef struct packed {
    logic valid;
    logic grant;
    logic zero_fill;
  } page_resp_t;

endpackage

// *** hdl/signature_rom.sv ***
/*
  Read-only store of the 32-byte tag signature, indexed by byte.
  Assumes the reader holds the index steady while it samples the byte.
*/
`timescale 1ns/10ps
`default_nettype none

module signature_rom (
  input  wire logic [4:0] idx_i,   // Byte index, 0 first
  output logic      [7:0] data_o   // Signature byte
);

  // fixed content: no write path exists
  always_comb begin
    data_o = tag_cmd_pkg::SIGNATURE_CONTENT[{idx_i, 3'h0} +: 8];
  end

endmodule // signature_rom

`default_nettype wire

// *** hdl/tag_cmd_core.sv ***
/*
  Command interpreter for counter read, password verify and signature read,
  plus the page access check for protected memory.
  Assumes framing logic delivers one request per frame with CRC already checked,
  appends CRC to reply bytes, and commits the failure count tearing-safe.
*/
// What this block does
// - Counter read is 39h, then counter number 02h, then CRC.
// - Accepted counter read returns three counter bytes plus CRC.
// - Protected counter read is refused with NAK until password verified.
// - When authenticated, protected counter read returns current value plus CRC.
// - Password verify is 1Bh, four password bytes, CRC; compared to stored password.
// - Matching password answers with two-byte acknowledge value plus CRC unless locked out.
// - Protected area only reachable after successful password verification.
// - Pages at or above first_protected_page are protected.
// - protection_scope_bit selects write-only or read-and-write protection.
// - Nonzero failed_attempt_limit counts failures in nonvolatile counter; zero means unlimited.
// - Reaching the limit permanently denies protected page access, even with correct password; auth held before lockout still allows counter read.
// - Signature read is 3Ch, 00h, CRC; returns 32 signature bytes plus CRC.
// - Signature is fixed and no command can change it.
// - Unauthenticated writes to protected pages are denied grant; authenticated ones proceed unless locked out.
// - Reads of password and acknowledge pages always return zero bytes.
`timescale 1ns/10ps
`default_nettype none

module tag_cmd_core (
  input  wire logic                   core_clk_i,        // 125 MHz clock
  input  wire logic                   rst_i,             // Sync reset, field entry
  input  wire tag_cmd_pkg::byte_beat_t rx_i,             // Request bytes, CRC stripped
  input  wire logic                   rx_crc_ok_i,       // CRC verdict, valid with last
  input  wire logic                   deselect_i,        // Leave authenticated state
  input  wire tag_cmd_pkg::tag_cfg_t  cfg_i,             // Configuration bytes
  input  wire logic [23:0]            counter_value_i,   // One-way counter
  input  wire logic [31:0]            stored_password_i, // Stored password
  input  wire logic [15:0]            password_ack_value_i, // Acknowledge value
  input  wire logic [2:0]             fail_count_i,      // Committed failure count
  input  wire logic                   fail_done_i,       // Failure count committed
  input  wire logic                   tx_ready_i,        // Reply sink ready
  input  wire tag_cmd_pkg::page_req_t page_req_i,        // Page access query
  output tag_cmd_pkg::byte_beat_t     tx_o,              // Reply bytes
  output logic                        nak_o,             // NAK pulse
  output logic [3:0]                  nak_code_o,        // NAK value
  output logic                        fail_wr_o,         // Failure count write pulse
  output logic [2:0]                  fail_wr_data_o,    // New failure count
  output tag_cmd_pkg::page_resp_t     page_resp_o,       // Page access verdict
  output logic                        authenticated_o,   // Authenticated state
  output logic                        locked_out_o       // Attempt limit reached
);

  typedef enum {ST_IDLE, ST_DECIDE, ST_NV_WAIT, ST_SEND, ST_NAK} state_t;

  localparam int RX_DEPTH_L = tag_cmd_pkg::RX_DEPTH;

  state_t      state;
  state_t      next_state;
  logic [7:0]  rx_buf [RX_DEPTH_L];
  logic [2:0]  rx_count;
  logic        crc_ok;
  logic        auth;
  logic [1:0]  kind;
  logic [1:0]  next_kind;
  logic [5:0]  tx_idx;
  logic [5:0]  last_idx;
  logic [7:0]  tx_byte;
  logic [23:0] counter_snap;
  logic [7:0]  sig_byte;
  logic [4:0]  sig_idx;
  logic        is_cnt;
  logic        is_sig;
  logic        is_pwd;
  logic        pwd_match;
  logic        locked;
  logic        tx_fire;
  logic        pg_protected;

  assign is_cnt = crc_ok && rx_count == tag_cmd_pkg::SHORT_REQ_LEN
                  && rx_buf[0] == tag_cmd_pkg::OP_COUNTER_READ
                  && rx_buf[1] == tag_cmd_pkg::COUNTER_ARG;
  assign is_sig = crc_ok && rx_count == tag_cmd_pkg::SHORT_REQ_LEN
                  && rx_buf[0] == tag_cmd_pkg::OP_SIGNATURE_READ
                  && rx_buf[1] == tag_cmd_pkg::SIGNATURE_ARG;
  // password compare, first received byte is the low byte
  assign is_pwd = crc_ok && rx_count == tag_cmd_pkg::PWD_REQ_LEN
                  && rx_buf[0] == tag_cmd_pkg::OP_PASSWORD_VERIFY;
  assign pwd_match = {rx_buf[4], rx_buf[3], rx_buf[2], rx_buf[1]} == stored_password_i;
  assign locked = cfg_i.failed_attempt_limit != tag_cmd_pkg::NO_LIMIT
                  && fail_count_i >= cfg_i.failed_attempt_limit;

  assign tx_fire = state == ST_SEND && tx_ready_i;

  // Frames arriving while a reply is in progress are dropped, not queued
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rx_count <= 3'h0;
      crc_ok   <= 1'b0;
    end else if (state == ST_IDLE && rx_i.valid) begin
      if (rx_count != 3'h7) begin
        rx_count <= rx_count + 3'h1;
      end
      if (rx_i.last) begin
        crc_ok <= rx_crc_ok_i;
      end
    end else if (state == ST_DECIDE) begin
      rx_count <= 3'h0;
    end
  end

  genvar g;
  generate
    for (g = 0; g < RX_DEPTH_L; g++) begin : g_rx
      always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
          rx_buf[g] <= 8'h00;
        end else if (state == ST_IDLE && rx_i.valid && rx_count == 3'(g)) begin
          rx_buf[g] <= rx_i.data;
        end
      end
    end
  endgenerate

  always_comb begin
    next_state = state;
    next_kind  = kind;
    case (state)
      ST_IDLE: begin
        if (rx_i.valid && rx_i.last) begin
          next_state = ST_DECIDE;
        end
      end
      ST_DECIDE: begin
        next_state = ST_NAK;
        if (is_cnt) begin
          if (!cfg_i.counter_read_protect_flag || auth) begin
            next_state = ST_SEND;
            next_kind  = tag_cmd_pkg::KIND_COUNTER;
          end
        end else if (is_sig) begin
          next_state = ST_SEND;
          next_kind  = tag_cmd_pkg::KIND_SIG;
        end else if (is_pwd && !locked) begin
          if (pwd_match) begin
            next_state = ST_SEND;
            next_kind  = tag_cmd_pkg::KIND_ACK;
          end else if (cfg_i.failed_attempt_limit != tag_cmd_pkg::NO_LIMIT) begin
            // commit the failure before the NAK leaves
            next_state = ST_NV_WAIT;
          end
        end
      end
      ST_NV_WAIT: begin
        if (fail_done_i) begin
          next_state = ST_NAK;
        end
      end
      ST_SEND: begin
        if (tx_ready_i && tx_idx == last_idx) begin
          next_state = ST_IDLE;
        end
      end
      ST_NAK: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      kind  <= tag_cmd_pkg::KIND_COUNTER;
    end else begin
      state <= next_state;
      kind  <= next_kind;
    end
  end

  // authenticated until deselect; a match in the same cycle wins
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      auth <= tag_cmd_pkg::AUTH_RESET;
    end else if (state == ST_DECIDE && is_pwd && !locked && pwd_match) begin
      auth <= 1'b1;
    end else if (deselect_i) begin
      auth <= tag_cmd_pkg::AUTH_RESET;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      fail_wr_o      <= 1'b0;
      fail_wr_data_o <= 3'h0;
    end else begin
      fail_wr_o <= state == ST_DECIDE && next_state == ST_NV_WAIT;
      if (state == ST_DECIDE) begin
        fail_wr_data_o <= fail_count_i + 3'h1;
      end
    end
  end

  assign sig_idx = state == ST_DECIDE ? 5'h00 : tx_idx[4:0] + 5'h01;

  signature_rom u_sig (
    .idx_i  (sig_idx),
    .data_o (sig_byte)
  );

  // counter snapshot keeps the three bytes consistent
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      counter_snap <= 24'h000000;
    end else if (state == ST_DECIDE) begin
      counter_snap <= counter_value_i;
    end
  end

  // Reply bytes go out low byte first
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      tx_idx   <= 6'h00;
      tx_byte  <= 8'h00;
      last_idx <= 6'h00;
    end else if (state == ST_DECIDE) begin
      tx_idx <= 6'h00;
      case (next_kind)
        tag_cmd_pkg::KIND_COUNTER: begin
          tx_byte  <= counter_value_i[7:0];
          last_idx <= tag_cmd_pkg::COUNTER_LAST_IDX;
        end
        tag_cmd_pkg::KIND_ACK: begin
          tx_byte  <= password_ack_value_i[7:0];
          last_idx <= tag_cmd_pkg::ACK_LAST_IDX;
        end
        default: begin
          tx_byte  <= sig_byte;
          last_idx <= tag_cmd_pkg::SIG_LAST_IDX;
        end
      endcase
    end else if (tx_fire && tx_idx != last_idx) begin
      tx_idx <= tx_idx + 6'h01;
      case (kind)
        tag_cmd_pkg::KIND_COUNTER: tx_byte <= counter_snap[{tx_idx[1:0] + 2'h1, 3'h0} +: 8];
        tag_cmd_pkg::KIND_ACK:     tx_byte <= password_ack_value_i[15:8];
        default:                   tx_byte <= sig_byte;
      endcase
    end
  end

  assign tx_o.valid = state == ST_SEND;
  assign tx_o.last  = state == ST_SEND && tx_idx == last_idx;
  assign tx_o.data  = tx_byte;
  assign nak_o      = state == ST_NAK;
  assign nak_code_o = tag_cmd_pkg::NAK_CODE;
  assign authenticated_o = auth;
  assign locked_out_o    = locked;

  assign pg_protected = page_req_i.page >= cfg_i.first_protected_page;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      page_resp_o <= '0;
    end else begin
      page_resp_o.valid <= page_req_i.valid;
      page_resp_o.grant <= !(pg_protected
                             && (page_req_i.is_write || cfg_i.protection_scope_bit)
                             && (!auth || locked));
      // secret pages read back as zero
      page_resp_o.zero_fill <= !page_req_i.is_write
                               && (page_req_i.page == cfg_i.password_page
                                   || page_req_i.page == cfg_i.password_ack_page);
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  a_cnt_protect_nak: assert property (state == ST_DECIDE && is_cnt
    && cfg_i.counter_read_protect_flag && !auth |=> nak_o ##1 state == ST_IDLE)
    else $error("protected counter read not refused");
  a_cnt_auth_serve: assert property (state == ST_DECIDE && is_cnt && auth
    |=> tx_o.valid && tx_o.data == $past(counter_value_i[7:0]))
    else $error("authenticated counter read not served");
  a_cnt_three_bytes: assert property (tx_fire && tx_o.last
    && kind == tag_cmd_pkg::KIND_COUNTER |-> tx_idx == 6'h02)
    else $error("counter reply not three bytes");
  a_sig_length: assert property (tx_fire && tx_o.last
    && kind == tag_cmd_pkg::KIND_SIG |-> tx_idx == 6'h1F)
    else $error("signature reply not 32 bytes");
  a_password_ack_value_reply: assert property (state == ST_DECIDE && is_pwd && pwd_match && !locked
    |=> auth && tx_o.valid && tx_o.data == $past(password_ack_value_i[7:0]))
    else $error("acknowledge value not sent on match");
  a_mismatch_stay: assert property (state == ST_DECIDE && is_pwd && !pwd_match
    && !auth && !locked && cfg_i.failed_attempt_limit == 3'h0 |=> nak_o && !auth)
    else $error("mismatch granted access");
  a_fail_count_wr: assert property (state == ST_DECIDE && is_pwd && !pwd_match
    && !locked && cfg_i.failed_attempt_limit != 3'h0
    |=> state == ST_NV_WAIT && fail_wr_o && !nak_o)
    else $error("failure not committed before NAK");
  a_lockout_deny: assert property (state == ST_DECIDE && is_pwd && locked
    |=> nak_o && !fail_wr_o && auth == $past(auth))
    else $error("locked tag accepted password");
  a_write_protect: assert property (page_req_i.valid && page_req_i.is_write
    && pg_protected && !auth |=> page_resp_o.valid && !page_resp_o.grant)
    else $error("unauthenticated protected write granted");
  a_secret_zero: assert property (page_req_i.valid && !page_req_i.is_write
    && page_req_i.page == cfg_i.password_page |=> page_resp_o.zero_fill)
    else $error("password page not zero filled");

  c_counter_read: cover property (tx_fire && tx_o.last && kind == tag_cmd_pkg::KIND_COUNTER);
  c_auth_success: cover property (!auth ##1 auth);
  c_lockout_nak:  cover property (state == ST_DECIDE && is_pwd && locked);
  c_sig_done:     cover property (tx_fire && tx_o.last && kind == tag_cmd_pkg::KIND_SIG);

endmodule // tag_cmd_core

`default_nettype wire

// *** test/nv_fail_store.sv ***
/*
  Behavioural model of the nonvolatile failure counter beside the tag core.
  Assumes count write pulses arrive one at a time and are never cut short.
*/
`timescale 1ns/10ps
`default_nettype none

module nv_fail_store #(
  parameter int COMMIT_CYCLES = 4   // Cycles one commit takes
) (
  input  wire logic       core_clk_i, // Clock
  input  wire logic       wr_i,       // Count write pulse
  input  wire logic [2:0] wr_data_i,  // New count
  output logic      [2:0] count_o,    // Committed count
  output logic            done_o      // Commit finished pulse
);
  int         busy = 0;
  logic [2:0] held = 3'h0;

  // No reset: the count survives field loss, as a nonvolatile cell would
  initial count_o = 3'h0;
  initial done_o = 1'b0;

  // tearing-safe commit: old count stands until the write is whole
  always @(posedge core_clk_i) begin
    done_o <= 1'b0;
    if (wr_i) begin
      busy <= COMMIT_CYCLES;
      held <= wr_data_i;
    end else if (busy == 1) begin
      count_o <= held;
      done_o  <= 1'b1;
      busy    <= 0;
    end else if (busy > 1) begin
      busy <= busy - 1;
    end
  end
endmodule // nv_fail_store
`default_nettype wire

// *** test/tb_top.sv ***
/*
  Self-checking bench for the tag command core: framed requests in, replies out.
  Assumes CRC is checked upstream and reported with the last request byte.
*/
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  localparam logic [23:0] CNT = 24'hA1B2C3;
  localparam logic [31:0] PWD = 32'h1234_5678;
  localparam logic [15:0] ACK = 16'hBEEF;

  logic                    core_clk_i = 1'b0;
  logic                    rst_i = 1'b1;
  tag_cmd_pkg::byte_beat_t rx = '0;
  tag_cmd_pkg::byte_beat_t tx;
  // secret pages sit inside the protected range
  tag_cmd_pkg::tag_cfg_t   cfg = {1'b0, 8'h10, 1'b0, 3'h0, 8'h2B, 8'h2C};
  tag_cmd_pkg::page_req_t  pq = '0;
  tag_cmd_pkg::page_resp_t pr;
  logic                    crc_ok = 1'b0;
  logic                    desel = 1'b0;
  logic                    rdy = 1'b1;
  logic                    nak, fwr, auth, lock, fdone, nk;
  logic [3:0]              nakc;
  logic [2:0]              fwd, fcnt;
  logic [7:0]              rsp [32];
  int                      rn, n_errors = 0, total_checks = 0, cyc = 0;

  tag_cmd_core i_tag_cmd_core (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .rx_i(rx), .rx_crc_ok_i(crc_ok),
    .deselect_i(desel), .cfg_i(cfg), .counter_value_i(CNT), .stored_password_i(PWD),
    .password_ack_value_i(ACK), .fail_count_i(fcnt), .fail_done_i(fdone),
    .tx_ready_i(rdy), .page_req_i(pq), .tx_o(tx), .nak_o(nak), .nak_code_o(nakc),
    .fail_wr_o(fwr), .fail_wr_data_o(fwd), .page_resp_o(pr),
    .authenticated_o(auth), .locked_out_o(lock));

  nv_fail_store i_nv_fail_store (
    .core_clk_i(core_clk_i), .wr_i(fwr), .wr_data_i(fwd), .count_o(fcnt), .done_o(fdone));

  always #4 core_clk_i = ~core_clk_i;

  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      $display("BAD %0t run did not finish", $time);
      n_errors++;
      final_report();
    end
  end

  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %0t byte got %h exp %h", $time, g, e);
    end
  endtask

  task automatic chk1(input logic g, input logic e);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %0t flag got %b exp %b", $time, g, e);
    end
  endtask

  // Sends one frame, then gathers reply bytes or a NAK; stall drops ready every other cycle
  task automatic req(input logic [47:0] f, input int n, input logic ok, input logic stall);
    for (int i = 0; i < n; i++) begin
      @(negedge core_clk_i);
      rx     <= '{1'b1, i == n - 1, f[8*i+:8]};
      crc_ok <= ok;
    end
    @(negedge core_clk_i);
    rx  <= '0;
    rdy = 1'b1;
    rn  = 0;
    nk  = 1'b0;
    // reply window, far shorter than the reader's timeout; silence fails the count
    for (int t = 0; t < 300; t++) begin
      if (nak === 1'b1) begin
        nk = 1'b1;
        break;
      end
      if (tx.valid === 1'b1 && rdy && rn < 32) begin
        rsp[rn] = tx.data;
        rn++;
        if (tx.last === 1'b1) break;
      end
      @(negedge core_clk_i);
      rdy = ~stall | ~rdy;
    end
  endtask

  task automatic nakreq(input logic [47:0] f, input int n, input logic ok);
    req(f, n, ok, 1'b0);
    chk1(nk, 1'b1);
    chk8(8'(rn), 8'h00);
  endtask

  // Query is taken at one edge; the verdict stands for the next cycle only
  task automatic page(input logic wr, input logic [7:0] pg, input logic g, input logic z);
    @(negedge core_clk_i);
    pq <= '{1'b1, wr, pg};
    @(negedge core_clk_i);
    chk1(pr.valid, 1'b1);
    chk1(pr.grant, g);
    chk1(pr.zero_fill, z);
    pq <= '0;
  endtask

  task automatic cnt_ok();
    req(48'h0239, 2, 1'b1, 1'b0);
    chk8(8'(rn), 8'h03);
    for (int k = 0; k < 3; k++) chk8(rsp[k], CNT[8*k+:8]);
  endtask

  initial begin
    repeat (8) @(posedge core_clk_i);
    @(negedge core_clk_i);
    rst_i = 1'b0;
    req(48'h003C, 2, 1'b1, 1'b1);                         // signature under stall
    chk8(8'(rn), 8'h20);
    for (int k = 0; k < 32; k++)
      chk8(rsp[k], tag_cmd_pkg::SIGNATURE_CONTENT[8*k+:8]);
    nakreq(48'h013C, 2, 1'b1);                            // reserved byte not zero
    nakreq(48'h0139, 2, 1'b1);                            // unknown counter
    nakreq(48'h0239, 2, 1'b0);                            // bad CRC
    cnt_ok();
    cfg.counter_read_protect_flag = 1'b1;
    nakreq(48'h0239, 2, 1'b1);
    nakreq({PWD ^ 32'h1, 8'h1B}, 5, 1'b1);
    chk1(auth, 1'b0);
    chk8({5'h0, fcnt}, 8'h00);                            // unlimited, no count
    page(1'b1, 8'h10, 1'b0, 1'b0);
    page(1'b1, 8'h0F, 1'b1, 1'b0);
    page(1'b0, 8'h10, 1'b1, 1'b0);                        // write-only scope
    cfg.protection_scope_bit = 1'b1;
    page(1'b0, 8'h10, 1'b0, 1'b0);
    req({PWD, 8'h1B}, 5, 1'b1, 1'b0);
    chk8(8'(rn), 8'h02);
    chk8(rsp[0], ACK[7:0]);
    chk8(rsp[1], ACK[15:8]);
    chk1(auth, 1'b1);
    cnt_ok();
    page(1'b1, 8'h10, 1'b1, 1'b0);
    page(1'b0, 8'h2B, 1'b1, 1'b1);
    page(1'b0, 8'h2C, 1'b1, 1'b1);
    desel = 1'b1;
    @(negedge core_clk_i);
    desel = 1'b0;
    @(negedge core_clk_i);
    chk1(auth, 1'b0);
    cfg.failed_attempt_limit = 3'h2;
    nakreq({PWD ^ 32'h8, 8'h1B}, 5, 1'b1);
    chk8({5'h0, fcnt}, 8'h01);
    chk1(lock, 1'b0);
    nakreq({PWD ^ 32'h8, 8'h1B}, 5, 1'b1);
    chk1(lock, 1'b1);
    nakreq({PWD, 8'h1B}, 5, 1'b1);                        // right password refused
    chk1(auth, 1'b0);
    page(1'b0, 8'h10, 1'b0, 1'b0);
    chk8({4'h0, nakc}, 8'h00);                            // NAK value
    final_report();
  end
endmodule // tb_top
`default_nettype wire
